//--- inc/acq_regs_pkg.sv
// constants, types and field layout for the acquisition register bank
// ==========================================================================
// Operation
// - select top bit 0: differential pair 0/1, 2/3, 4/5 or 6/7 by low bits
// - polarity 0 makes the even line positive, 1 makes the odd line positive
// - select top bit 1: low three bits pick one positive line against ground
// - every register is eight bits; four user registers among reserved addresses
// - reset clears every bit of every user register
// - result is read-only at addresses zero and one
// - result is presented in two's complement or straight binary form per format bit
// - low byte: result bits 5..0 in D7-D2, D1 zero, D0 over-range flag
// - high byte: result bits 13..6 in D7-D0
// - result bits shift out msb or lsb first per bit-order select
// - over-range flag set when any amplifier limit is exceeded
// - limit register at address two is read-only, six flags, D7-D6 zero
// - D5 neg output low, D4 neg output high, D3 neg input high
// - D2 pos output low, D1 pos output high, D0 pos input high
// - control at address three: format D5, read-back D3-D2, divide D1-D0
// - format bit 0 gives two's complement, 1 gives straight binary
// - read-back 00 explicit, 01 msb first, 10 lsb first, 11 msb only; the code only stores this field, i_lsb_first sets the bit order
// - divide field divides the conversion clock by 2, 4, 8 or 16
package acq_regs_pkg;

    // ======================================================================
    // register map
    localparam logic [4:0] ADDR_RESULT_LOW  = 5'h00;
    localparam logic [4:0] ADDR_RESULT_HIGH = 5'h01;
    localparam logic [4:0] ADDR_LIMIT_FLAGS = 5'h02;
    localparam logic [4:0] ADDR_CONV_CTRL   = 5'h03;
    localparam logic [7:0] CONV_CTRL_RESET  = 8'h00;

    // ======================================================================
    // field positions
    localparam int CTRL_FORMAT_POS    = 5;
    localparam int CTRL_READBACK_LSB  = 2;
    localparam int CTRL_DIVIDE_LSB    = 0;
    localparam int LOW_RESULT_LSB     = 2;
    localparam int LOW_OVERRANGE_POS  = 0;
    localparam int RESULT_LOW_BITS    = 6;

    // ======================================================================
    // timing counts
    localparam logic [3:0] SHIFT_COUNT = 4'h8;
    // divider end counts: rising input edges between output toggles, less one
    localparam logic [2:0] DIV_TOP_BY1 = 3'h0;
    localparam logic [2:0] DIV_TOP_BY2 = 3'h1;
    localparam logic [2:0] DIV_TOP_BY4 = 3'h3;
    localparam logic [2:0] DIV_TOP_BY8 = 3'h7;

    // ======================================================================
    // read-back mode codes
    typedef enum logic [1:0] {
        READBACK_EXPLICIT  = 2'h0,
        READBACK_MSB_FIRST = 2'h1,
        READBACK_LSB_FIRST = 2'h2,
        READBACK_MSB_ONLY  = 2'h3
    } readback_mode_t;

    typedef struct packed {
        logic          straight_binary_select;
        readback_mode_t readback_mode_field;
        logic [1:0]    clock_divide_field;
    } conv_ctrl_t;

    typedef struct packed {
        logic neg_output_low_flag;
        logic neg_output_high_flag;
        logic neg_input_high_flag;
        logic pos_output_low_flag;
        logic pos_output_high_flag;
        logic pos_input_high_flag;
    } limit_flags_t;

    // line selection: positive line one-hot, negative line one-hot or all zero against ground, ground reference
    typedef struct packed {
        logic [7:0] pos_lines;
        logic [7:0] neg_lines;
        logic       ground_ref;
    } mux_sel_t;

    // register access request from the serial port logic
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [4:0] addr;
        logic [7:0] wdata;
    } reg_req_t;

endpackage

//--- core/acq_reg_bank.sv
// register bank, mux decode, result formatting and clock divider
`timescale 1ns/1ps
`default_nettype none
module acq_reg_bank #(
    parameter int RESULT_WIDTH = 14
) (
    // clock, reset, enable
    input  wire logic                       i_clk,
    input  wire logic                       i_rst,
    input  wire logic                       i_ce,
    // register access
    input  wire acq_regs_pkg::reg_req_t     i_req,
    output logic [7:0]                      o_rdata,
    output logic                            o_rvalid,
    output logic                            o_hit,
    // serial bit order: 1 = lsb first
    input  wire logic                       i_lsb_first,
    // conversion inputs
    input  wire logic                       i_conv_done,
    input  wire logic [RESULT_WIDTH-1:0]    i_conv_result,
    input  wire acq_regs_pkg::limit_flags_t i_limit_flags,
    input  wire logic [3:0]                 i_mux_code,
    // conversion clock
    input  wire logic                       i_conversion_clock_input,
    // outputs
    output acq_regs_pkg::mux_sel_t          o_mux_sel,
    output logic                            o_divided_converter_clock,
    output acq_regs_pkg::conv_ctrl_t        o_ctrl,
    output logic                            o_shift_bit,
    output logic                            o_shift_valid
);
    import acq_regs_pkg::*;

    // ======================================================================
    // elaboration checks
    // byte packing is fixed to a fourteen-bit result split six and eight
    if (RESULT_WIDTH != 14) begin : g_bad_width
        $error("result width must be 14");
    end

    if (LOW_RESULT_LSB + RESULT_LOW_BITS != 8) begin : g_bad_low_split
        $error("low result field must end at bit 7");
    end

    if (RESULT_WIDTH - RESULT_LOW_BITS != 8) begin : g_bad_high_split
        $error("high result field must fill one byte");
    end

    // ======================================================================
    // state
    typedef struct packed {
        conv_ctrl_t      ctrl;
        logic [13:0]     result;
        logic            over_range;
        limit_flags_t    limits;
        mux_sel_t        mux;
        logic [7:0]      rdata;
        logic            rvalid;
        logic            hit;
        logic [7:0]      shreg;
        logic [3:0]      shcnt;
        logic            shbit;
        logic            shvalid;
        logic [2:0]      divcnt;
        logic            div_clk;
        logic            conv_clk_d;
    } state_t;

    state_t      st_reg;
    state_t      st_next;
    logic [13:0] fmt_result;
    logic [7:0]  low_byte;
    logic [7:0]  high_byte;
    logic [7:0]  ctrl_byte;
    logic [2:0]  div_top;
    logic        conv_clk_rise;
    logic        wr_ctrl;

    // ======================================================================
    // line selection decode
    function automatic mux_sel_t decode_mux(input logic [3:0] code);
        mux_sel_t s;
        s = '0;
        if (code[3]) begin
            s.pos_lines[code[2:0]] = 1'b1;
            s.ground_ref           = 1'b1;
        end else begin
            // even line positive unless polarity set
            s.pos_lines[{code[1:0], code[2]}]  = 1'b1;
            s.neg_lines[{code[1:0], ~code[2]}] = 1'b1;
        end
        return s;
    endfunction

    // ======================================================================
    // result packing
    // straight binary flips only the sign bit of the two's complement value
    function automatic logic [13:0] format_result(
        input logic [13:0] result,
        input logic        straight_binary
    );
        logic [13:0] f;
        f     = result;
        f[13] = result[13] ^ straight_binary;
        return f;
    endfunction

    // bit 1 stays zero from the clear
    function automatic logic [7:0] pack_low_byte(
        input logic [13:0] result,
        input logic        over_range
    );
        logic [7:0] b;
        b                                    = 8'h00;
        b[LOW_RESULT_LSB +: RESULT_LOW_BITS] = result[RESULT_LOW_BITS-1:0];
        b[LOW_OVERRANGE_POS]                 = over_range;
        return b;
    endfunction

    function automatic logic [7:0] pack_high_byte(input logic [13:0] result);
        logic [7:0] b;
        b = result[13:RESULT_LOW_BITS];
        return b;
    endfunction

    // ======================================================================
    // control register packing
    // unused bits read zero whatever was written to them
    function automatic logic [7:0] pack_ctrl_byte(input conv_ctrl_t c);
        logic [7:0] b;
        b                        = 8'h00;
        b[CTRL_FORMAT_POS]       = c.straight_binary_select;
        b[CTRL_READBACK_LSB +: 2] = c.readback_mode_field;
        b[CTRL_DIVIDE_LSB +: 2]  = c.clock_divide_field;
        return b;
    endfunction

    function automatic conv_ctrl_t unpack_ctrl(input logic [7:0] wdata);
        conv_ctrl_t c;
        c.straight_binary_select = wdata[CTRL_FORMAT_POS];
        c.readback_mode_field    =
            readback_mode_t'(wdata[CTRL_READBACK_LSB +: 2]);
        c.clock_divide_field     = wdata[CTRL_DIVIDE_LSB +: 2];
        return c;
    endfunction

    // ======================================================================
    // divider end count per divide code
    function automatic logic [2:0] divide_top(input logic [1:0] code);
        logic [2:0] t;
        unique case (code)
            2'h0: t = DIV_TOP_BY1;
            2'h1: t = DIV_TOP_BY2;
            2'h2: t = DIV_TOP_BY4;
            2'h3: t = DIV_TOP_BY8;
        endcase
        return t;
    endfunction

    function automatic logic is_result_addr(input logic [4:0] addr);
        return (addr == ADDR_RESULT_LOW) || (addr == ADDR_RESULT_HIGH);
    endfunction

    // ======================================================================
    // register contents
    always_comb begin
        fmt_result    = format_result(st_reg.result,
                                      st_reg.ctrl.straight_binary_select);
        low_byte      = pack_low_byte(fmt_result, st_reg.over_range);
        high_byte     = pack_high_byte(fmt_result);
        ctrl_byte     = pack_ctrl_byte(st_reg.ctrl);
        div_top       = divide_top(st_reg.ctrl.clock_divide_field);
        conv_clk_rise = i_conversion_clock_input && !st_reg.conv_clk_d;
        wr_ctrl       = i_req.wr && (i_req.addr == ADDR_CONV_CTRL);
    end

    // ======================================================================
    // next state
    always_comb begin
        st_next         = st_reg;
        st_next.rvalid  = 1'b0;
        st_next.shvalid = 1'b0;
        st_next.mux     = decode_mux(i_mux_code);

        // capture
        if (i_conv_done) begin
            st_next.result     = 14'(i_conv_result);
            st_next.limits     = i_limit_flags;
            st_next.over_range = |i_limit_flags;
        end

        // only the control register accepts writes; result and limits hold
        if (wr_ctrl) begin
            st_next.ctrl = unpack_ctrl(i_req.wdata);
        end

        // reads
        if (i_req.rd) begin
            st_next.rvalid = 1'b1;
            st_next.hit    = 1'b1;
            unique case (i_req.addr)
                ADDR_RESULT_LOW: begin
                    st_next.rdata = low_byte;
                end
                ADDR_RESULT_HIGH: begin
                    st_next.rdata = high_byte;
                end
                ADDR_LIMIT_FLAGS: begin
                    st_next.rdata = {2'h0, st_reg.limits};
                end
                ADDR_CONV_CTRL: begin
                    st_next.rdata = ctrl_byte;
                end
                default: begin
                    st_next.rdata = 8'h00;
                    st_next.hit   = 1'b0;
                end
            endcase
            // a new result read restarts any burst still in progress
            if (is_result_addr(i_req.addr)) begin
                st_next.shreg = st_next.rdata;
                st_next.shcnt = SHIFT_COUNT;
            end
        end else if (st_reg.shcnt != 4'h0) begin
            // serialise read result bytes in the chosen bit order
            st_next.shvalid = 1'b1;
            st_next.shcnt   = st_reg.shcnt - 4'h1;
            if (i_lsb_first) begin
                st_next.shbit = st_reg.shreg[0];
                st_next.shreg = {1'b0, st_reg.shreg[7:1]};
            end else begin
                st_next.shbit = st_reg.shreg[7];
                st_next.shreg = {st_reg.shreg[6:0], 1'b0};
            end
        end

        // divider advances on rising edges of the sampled conversion clock;
        // the sampled input must not exceed half the system clock rate
        st_next.conv_clk_d = i_conversion_clock_input;
        if (conv_clk_rise) begin
            if (st_reg.divcnt >= div_top) begin
                st_next.divcnt  = 3'h0;
                st_next.div_clk = ~st_reg.div_clk;
            end else begin
                st_next.divcnt  = st_reg.divcnt + 3'h1;
            end
        end
    end

    // ======================================================================
    // state register; all user bits clear on reset
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            st_reg <= '0;
        end else if (i_ce) begin
            st_reg <= st_next;
        end
    end

    // ======================================================================
    // outputs, all straight from the state register
    assign o_rdata                   = st_reg.rdata;
    assign o_rvalid                  = st_reg.rvalid;
    assign o_hit                     = st_reg.hit;
    assign o_mux_sel                 = st_reg.mux;
    assign o_divided_converter_clock = st_reg.div_clk;
    assign o_ctrl                    = st_reg.ctrl;
    assign o_shift_bit               = st_reg.shbit;
    assign o_shift_valid             = st_reg.shvalid;
endmodule
`default_nettype wire

//--- verification/acq_reg_bank_checker.sv
// port assertions for the acquisition register bank
`timescale 1ns/1ps
`default_nettype none
module acq_reg_bank_checker
    import acq_regs_pkg::*;
#(
    parameter int RESULT_WIDTH = 14
) (
    input wire logic                       i_clk,
    input wire logic                       i_rst,
    input wire logic                       i_ce,
    input wire acq_regs_pkg::reg_req_t     i_req,
    input wire logic [7:0]                 o_rdata,
    input wire logic                       o_rvalid,
    input wire logic                       o_hit,
    input wire logic                       i_conv_done,
    input wire logic [RESULT_WIDTH-1:0]    i_conv_result,
    input wire acq_regs_pkg::limit_flags_t i_limit_flags,
    input wire logic [3:0]                 i_mux_code,
    input wire acq_regs_pkg::mux_sel_t     o_mux_sel,
    input wire acq_regs_pkg::conv_ctrl_t   o_ctrl,
    input wire logic                       o_shift_valid
);
    logic [RESULT_WIDTH-1:0] res_reg;
    limit_flags_t            flg_reg;
    // a capture in the same cycle would make the expected byte ambiguous
    wire logic       rd_ok = i_ce && i_req.rd && !i_req.wr && !i_conv_done;
    wire logic [4:0] wbits = {i_req.wdata[5], i_req.wdata[3:0]};
    wire logic [2:0] dp = {i_mux_code[1:0], i_mux_code[2]};
    wire mux_sel_t   diff_sel = {8'h01 << dp, 8'h01 << (dp ^ 3'h1), 1'b0};
    wire mux_sel_t   se_sel = {8'h01 << i_mux_code[2:0], 8'h00, 1'b1};
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            res_reg <= '0;
            flg_reg <= '0;
        end else if (i_ce && i_conv_done) begin
            res_reg <= i_conv_result;
            flg_reg <= i_limit_flags;
        end
    end
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);
    sequence s_result_read; rd_ok && i_req.addr <= ADDR_RESULT_HIGH; endsequence
    sequence s_shift_burst; ##1 o_shift_valid [*8]; endsequence
    a_read_answer: assert property (i_ce && i_req.rd |=> o_rvalid)
        else $error("read not answered");
    a_shift_burst: assert property (s_result_read |=> s_shift_burst)
        else $error("result shift burst short");
    a_low_byte: assert property (rd_ok && i_req.addr == ADDR_RESULT_LOW
        |=> o_rdata == {res_reg[5:0], 1'b0, |flg_reg}) else $error("low byte wrong");
    a_high_byte: assert property (rd_ok && i_req.addr == ADDR_RESULT_HIGH |=> o_rdata ==
        {res_reg[13] ^ $past(o_ctrl.straight_binary_select), res_reg[12:6]})
        else $error("high byte wrong");
    a_limit_read: assert property (rd_ok && i_req.addr == ADDR_LIMIT_FLAGS
        |=> o_rdata == {2'b00, flg_reg}) else $error("limit byte wrong");
    a_unmapped_zero: assert property (rd_ok && i_req.addr > ADDR_CONV_CTRL
        |=> o_rdata == 8'h00 && !o_hit) else $error("unmapped read not zero");
    a_ctrl_write: assert property (i_ce && i_req.wr && i_req.addr == ADDR_CONV_CTRL
        |=> o_ctrl == $past(wbits)) else $error("control write lost");
    a_ro_kept: assert property (i_ce && i_req.wr && i_req.addr != ADDR_CONV_CTRL
        |=> $stable(o_ctrl)) else $error("read-only write changed control");
    a_diff_pair: assert property (!$past(i_rst) && i_ce && !i_mux_code[3]
        |=> o_mux_sel == $past(diff_sel)) else $error("pair decode wrong");
    a_single_line: assert property (!$past(i_rst) && i_ce && i_mux_code[3]
        |=> o_mux_sel == $past(se_sel)) else $error("single line decode wrong");
endmodule
bind acq_reg_bank acq_reg_bank_checker #(.RESULT_WIDTH(RESULT_WIDTH)) acq_reg_bank_checker_inst (
    .i_clk(i_clk), .i_rst(i_rst), .i_ce(i_ce), .i_req(i_req), .o_rdata(o_rdata),
    .o_rvalid(o_rvalid), .o_hit(o_hit), .i_conv_done(i_conv_done),
    .i_conv_result(i_conv_result), .i_limit_flags(i_limit_flags), .i_mux_code(i_mux_code),
    .o_mux_sel(o_mux_sel), .o_ctrl(o_ctrl), .o_shift_valid(o_shift_valid));
`default_nettype wire

//--- verification/acq_host_model.sv
// host controller model issuing register reads and writes
`timescale 1ns/1ps
`default_nettype none
module acq_host_model
    import acq_regs_pkg::*;
(
    input  wire logic                   i_clk,
    input  wire logic                   i_rvalid,
    input  wire logic [7:0]             i_rdata,
    input  wire logic                   i_shift_bit,
    output var acq_regs_pkg::reg_req_t  o_req
);
    initial o_req = '0;
    task automatic write(input logic [4:0] addr, input logic [7:0] data);
        @(posedge i_clk);
        o_req <= '{wr: 1'b1, rd: 1'b0, addr: addr, wdata: data};
        @(posedge i_clk);
        o_req.wr <= 1'b0;
    endtask
    // waits out the shift burst so two reads never overlap it
    task automatic read(input logic [4:0] addr, output logic [7:0] data, output logic [7:0] bits);
        @(posedge i_clk);
        o_req <= '{wr: 1'b0, rd: 1'b1, addr: addr, wdata: ~o_req.wdata};
        @(posedge i_clk);
        o_req.rd <= 1'b0;
        @(posedge i_clk);
        data = i_rvalid ? i_rdata : 8'hxx;
        for (int i = 0; i < 8; i++) begin
            @(posedge i_clk);
            bits = {bits[6:0], i_shift_bit};
        end
    endtask
endmodule
`default_nettype wire

//--- verification/acq_reg_bank_tb_top.sv
// self-checking bench for the acquisition register bank
`timescale 1ns/1ps
`default_nettype none
module acq_reg_bank_tb_top;
    import acq_regs_pkg::*;
    logic         i_clk = 1'b0;
    logic         i_rst = 1'b1;
    logic         i_lsb_first = 1'b0;
    logic         conv_clk = 1'b0;
    logic         div_clk;
    logic         div_clk_prev;
    int           toggles;
    logic         i_conv_done = 1'b0;
    logic [13:0]  i_conv_result = '0;
    limit_flags_t i_limit_flags = '0;
    logic [3:0]   i_mux_code = '0;
    reg_req_t     req;
    logic [7:0]   rdata, d, b;
    logic         rvalid, hit, shift_bit;
    mux_sel_t     mux_sel;
    conv_ctrl_t   ctrl;
    int           fails = 0;
    int           n_checks = 0;
    always #5 i_clk = ~i_clk;
    acq_reg_bank #(.RESULT_WIDTH(14)) acq_reg_bank_inst (
        .i_clk(i_clk), .i_rst(i_rst), .i_ce(1'b1), .i_req(req), .o_rdata(rdata),
        .o_rvalid(rvalid), .o_hit(hit), .i_lsb_first(i_lsb_first), .i_conv_done(i_conv_done),
        .i_conv_result(i_conv_result), .i_limit_flags(i_limit_flags), .i_mux_code(i_mux_code),
        .i_conversion_clock_input(conv_clk), .o_mux_sel(mux_sel),
        .o_divided_converter_clock(div_clk),
        .o_ctrl(ctrl), .o_shift_bit(shift_bit), .o_shift_valid());
    acq_host_model acq_host_model_inst (.i_clk(i_clk), .i_rvalid(rvalid), .i_rdata(rdata),
        .i_shift_bit(shift_bit), .o_req(req));
    task automatic check(input string what, input logic [16:0] seen, input logic [16:0] exp);
        n_checks++;
        if (seen !== exp) begin
            fails++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task automatic rd_chk(input logic [4:0] a, input logic [7:0] e);
        acq_host_model_inst.read(a, d, b);
        check("rdata", {9'h000, d}, {9'h000, e});
    endtask
    task automatic conv(input logic [13:0] r, input logic [5:0] f);
        i_conv_result <= r;
        i_limit_flags <= f;
        i_conv_done <= 1'b1;
        @(posedge i_clk);
        i_conv_done <= 1'b0;
    endtask
    function automatic mux_sel_t exp_mux(input logic [3:0] c);
        logic [2:0] p;
        p = {c[1:0], c[2]};
        return c[3] ? {8'h01 << c[2:0], 8'h00, 1'b1} : {8'h01 << p, 8'h01 << (p ^ 3'h1), 1'b0};
    endfunction
    initial begin
        repeat (5) @(posedge i_clk);
        i_rst <= 1'b0;
        for (int a = 0; a < 4; a++) rd_chk(5'(a), 8'h00);
        rd_chk(5'h1f, 8'h00);
        check("hit", {16'h0000, hit}, 17'h0);
        acq_host_model_inst.write(ADDR_CONV_CTRL, 8'hff);
        rd_chk(ADDR_CONV_CTRL, 8'h2f);
        for (int m = 0; m < 4; m++) begin
            acq_host_model_inst.write(ADDR_CONV_CTRL, {4'h0, 2'(m), 2'(m)});
            @(posedge i_clk);
            check("ctrl", {12'h000, ctrl}, {13'h0000, 2'(m), 2'(m)});
        end
        for (int k = 0; k < 4; k++) begin
            acq_host_model_inst.write(ADDR_CONV_CTRL, {6'h00, 2'(k)});
            toggles = 0;
            div_clk_prev = div_clk;
            for (int e = 0; e < 16; e++) begin
                conv_clk <= 1'b1;
                @(posedge i_clk);
                conv_clk <= 1'b0;
                @(posedge i_clk);
                if (div_clk !== div_clk_prev) toggles++;
                div_clk_prev = div_clk;
            end
            check("divider", 17'(toggles), 17'(16 >> k));
        end
        conv(14'h2a5b, 6'h25);
        rd_chk(ADDR_RESULT_LOW, 8'h6d);
        rd_chk(ADDR_RESULT_HIGH, 8'ha9);
        check("msb first", {9'h000, b}, 17'h000a9);
        rd_chk(ADDR_LIMIT_FLAGS, 8'h25);
        i_lsb_first <= 1'b1;
        rd_chk(ADDR_RESULT_HIGH, 8'ha9);
        check("lsb first", {9'h000, b}, 17'h00095);
        acq_host_model_inst.write(ADDR_CONV_CTRL, 8'h20);
        rd_chk(ADDR_RESULT_HIGH, 8'h29);
        for (int a = 0; a < 3; a++) acq_host_model_inst.write(5'(a), 8'hff);
        rd_chk(ADDR_RESULT_LOW, 8'h6d);
        rd_chk(ADDR_LIMIT_FLAGS, 8'h25);
        conv(14'h2a5b, 6'h00);
        rd_chk(ADDR_RESULT_LOW, 8'h6c);
        i_rst <= 1'b1;
        @(posedge i_clk);
        i_rst <= 1'b0;
        check("ctrl after reset", {12'h000, ctrl}, 17'h0);
        rd_chk(ADDR_RESULT_LOW, 8'h00);
        rd_chk(ADDR_CONV_CTRL, 8'h00);
        for (int c = 0; c < 16; c++) begin
            i_mux_code <= 4'(c);
            repeat (2) @(posedge i_clk);
            check("mux", mux_sel, exp_mux(4'(c)));
        end
        wrap_up();
    end
    initial begin
        #100us;
        fails++;
        wrap_up();
    end
endmodule
`default_nettype wire
